// ===== inc/irq_map_pkg.sv
// constants, codes and carrier types of the mid-range interrupt vector map
package irq_map_pkg;
  localparam int NSRC     = 31;        // sources of default priority 22..52
  localparam int NPERIPH  = 28;        // on-chip request lines
  localparam int NPIN     = 3;         // external pins 8, 9, 10
  localparam int PRI_BASE = 22;        // default priority of index 0
  localparam int PIN_IDX  = 17;        // index of external pin 8

  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MASK   = 8'h04;
  localparam logic [7:0] OFS_EDGE   = 8'h08;
  localparam logic [7:0] OFS_GRANT  = 8'h0c;
  localparam logic [7:0] OFS_RESUME = 8'h10;

  // values after reset
  localparam logic [30:0] RST_STATUS = 31'h0;
  localparam logic [30:0] RST_MASK   = 31'h0;
  localparam logic [5:0]  RST_EDGE   = 6'h15;   // rising edge on each pin
  localparam logic [31:0] RST_RESUME = 32'h0;

  // grant register field positions
  localparam int GRANT_VALID_BIT = 31;
  localparam int GRANT_IDX_LSB   = 16;

  // exception code layout: three runs, gaps 02c0..02f0 and 03d0..0400 unused
  localparam logic [15:0] CODE_STEP   = 16'h0010;
  localparam logic [15:0] CODE_BASE_A = 16'h01e0;
  localparam logic [15:0] CODE_BASE_B = 16'h0300;
  localparam logic [15:0] CODE_BASE_C = 16'h0410;
  localparam logic [4:0]  SPLIT_B     = 5'd14;
  localparam logic [4:0]  SPLIT_C     = 5'd27;

  // winning request as handed to the core
  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic [15:0] code;
    logic [31:0] vector;
  } grant_s;

  // exception code of a source index
  function automatic logic [15:0] code_of(input logic [4:0] idx);
    logic [15:0] k;
    k = 16'h0;
    if (idx >= SPLIT_C) begin
      k = {11'h0, idx - SPLIT_C};
      code_of = 16'(CODE_BASE_C + k * CODE_STEP);
    end else if (idx >= SPLIT_B) begin
      k = {11'h0, idx - SPLIT_B};
      code_of = 16'(CODE_BASE_B + k * CODE_STEP);
    end else begin
      k = {11'h0, idx};
      code_of = 16'(CODE_BASE_A + k * CODE_STEP);
    end
  endfunction
endpackage

// ===== hdl/maskable_irq_vector_map_mid.sv
// maskable interrupt source table, priorities 22..52, with ahb-lite registers
// Function
// [RULE1] timer p2 ccmatch1: priority 22, code 01e0, vector 000001e0
// [RULE2] timer p3 ccmatch1: priority 25, code 0210, vector 00000210
// [RULE3] ext pin8 valid edge: priority 39, code 0330, vector 00000330
// [RULE4] key return: priority 36, code 0300, vector 00000300
// [RULE5] watch reference: priority 38, code 0320, apart from watch interval
// [RULE6] timer q1 ccmatch0: priority 43, code 0370, vector 00000370
// [RULE7] timer q1 ccmatch1: priority 44, code 0380, vector 00000380
// [RULE8] timer q1 ccmatch2: priority 45, code 0390, vector 00000390
// [RULE9] timer q1 ccmatch3: priority 46, code 03a0, vector 000003a0
// [RULE10] simultaneous pending requests: smallest priority number is granted
// [RULE11] saved resume address is the next instruction's address
// [RULE12] vector equals exception code zero-extended to 32 bits
// [RULE13] codes 02c0..02f0 and 03d0..0400 have no source
`timescale 1ns/1ps
module maskable_irq_vector_map_mid
  import irq_map_pkg::*;
(
  // clock, reset, enable
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          clk_en,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  // request sources
  input  wire logic [irq_map_pkg::NPERIPH-1:0] periph_req,
  input  wire logic [irq_map_pkg::NPIN-1:0]    ext_pin_in,
  // cpu core side
  input  wire logic                          cpu_ack,
  input  wire logic [31:0]                   next_pc,
  output irq_map_pkg::grant_s                cpu_grant,
  output logic [31:0]                        resume_address,
  output logic                               irq
);
  import irq_map_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // lowest set index wins
  function automatic logic [5:0] pick(input logic [NSRC-1:0] v);
    pick = 6'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick = {1'b1, 5'(i)};
      end
    end
  endfunction

  logic [30:0]        status_r;
  logic [30:0]        status_nxt;
  logic [30:0]        mask_r;
  logic [5:0]         edge_r;
  logic [31:0]        resume_r;
  grant_s             grant_r;
  logic [NPIN-1:0]    pin_s1_r;
  logic [NPIN-1:0]    pin_s2_r;
  logic [NPIN-1:0]    pin_s3_r;
  logic [NPIN-1:0]    pin_lvl_r;
  logic [NPIN-1:0]    pin_edge;
  logic [NSRC-1:0]    req_all;
  logic [NSRC-1:0]    pend_en;
  logic [5:0]         win;
  logic               wr_pend_r;
  logic [7:0]         wr_ofs_r;
  logic [31:0]        rd_data_r;
  logic               addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // external pin synchronisers, three stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else if (clk_en) begin
      pin_s1_r <= ext_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // filtered level follows once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_lvl_r <= '0;
    end else if (clk_en) begin
      for (int p = 0; p < NPIN; p++) begin
        if (pin_s2_r[p] == pin_s3_r[p]) begin
          pin_lvl_r[p] <= pin_s3_r[p];
        end
      end
    end
  end

  // valid edge per pin: bit 0 rising, bit 1 falling
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      pin_edge[p] = (pin_s2_r[p] == pin_s3_r[p]) && (pin_s3_r[p] != pin_lvl_r[p]) &&
                    ((pin_s3_r[p] && edge_r[2*p]) || (!pin_s3_r[p] && edge_r[2*p+1])); // [RULE3]
    end
  end

  // source table: pins 8..10 sit at priorities 39..41
  assign req_all = {periph_req[NPERIPH-1:PIN_IDX], pin_edge, periph_req[PIN_IDX-1:0]}; // [RULE5]

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h0;
    end else if (clk_en) begin
      wr_pend_r <= addr_ok && hwrite;
      wr_ofs_r  <= haddr[7:0];
    end
  end

  // read data registered at the address phase, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data_r <= 32'h0;
    end else if (clk_en && addr_ok && !hwrite) begin
      case (haddr[7:0])
        OFS_STATUS: rd_data_r <= {1'b0, status_r};
        OFS_MASK:   rd_data_r <= {1'b0, mask_r};
        OFS_EDGE:   rd_data_r <= {26'h0, edge_r};
        OFS_GRANT:  rd_data_r <= {grant_r.valid, 10'h0, grant_r.idx, grant_r.code};
        OFS_RESUME: rd_data_r <= resume_r;
        default:    rd_data_r <= 32'h0;
      endcase
    end
  end
  assign hrdata = rd_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // sticky pending flags: set wins over write-one-clear and acknowledge
  always_comb begin
    status_nxt = status_r;
    if (wr_pend_r && wr_ofs_r == OFS_STATUS) begin
      status_nxt = status_nxt & ~hwdata[30:0];
    end
    if (cpu_ack && grant_r.valid) begin
      status_nxt[grant_r.idx] = 1'b0;
    end
    status_nxt = status_nxt | req_all;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= RST_STATUS;
    end else if (clk_en) begin
      status_r <= status_nxt;
    end
  end

  // mask and edge configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= RST_MASK;
      edge_r <= RST_EDGE;
    end else if (clk_en && wr_pend_r) begin
      if (wr_ofs_r == OFS_MASK) begin
        mask_r <= hwdata[30:0];
      end
      if (wr_ofs_r == OFS_EDGE) begin
        edge_r <= hwdata[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority resolution and code lookup
  assign pend_en = status_r & mask_r;
  assign win     = pick(pend_en); // [RULE10]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant_r <= '0;
    end else if (clk_en) begin
      // an idle grant reads as all zeros, as after reset
      grant_r.valid  <= win[5];
      grant_r.idx    <= win[4:0]; // [RULE6] [RULE7] [RULE8] [RULE9] [RULE13]
      grant_r.code   <= win[5] ? code_of(win[4:0]) : 16'h0; // [RULE1] [RULE2] [RULE4] [RULE5]
      grant_r.vector <= win[5] ? {16'h0, code_of(win[4:0])} : 32'h0; // [RULE12]
    end
  end

  // resume address captured when the core takes the interrupt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resume_r <= RST_RESUME;
    end else if (clk_en && cpu_ack && grant_r.valid) begin
      resume_r <= next_pc; // [RULE11]
    end
  end

  assign cpu_grant      = grant_r;
  assign resume_address = resume_r;
  assign irq            = |pend_en;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_taken;
    clk_en && cpu_ack && grant_r.valid;
  endsequence

  property p_tp2cc1;
    grant_r.valid && grant_r.idx == 5'd0 |-> grant_r.code == 16'h01e0 &&
      grant_r.vector == 32'h000001e0;
  endproperty
  a_tp2cc1: assert property (p_tp2cc1) else $error("priority 22 code wrong"); // [RULE1]

  property p_tp3cc1;
    grant_r.valid && grant_r.idx == 5'd3 |-> grant_r.vector == 32'h00000210;
  endproperty
  a_tp3cc1: assert property (p_tp3cc1) else $error("priority 25 code wrong"); // [RULE2]

  property p_pin8;
    clk_en && pin_edge[0] ##1 clk_en |-> status_r[17];
  endproperty
  a_pin8: assert property (p_pin8) else $error("pin 8 edge not pending"); // [RULE3]

  property p_pin8_code;
    grant_r.valid && grant_r.idx == 5'd17 |-> grant_r.code == 16'h0330;
  endproperty
  a_pin8_code: assert property (p_pin8_code) else $error("priority 39 code wrong"); // [RULE3]

  property p_keyret;
    grant_r.valid && grant_r.idx == 5'd14 |-> grant_r.code == 16'h0300;
  endproperty
  a_keyret: assert property (p_keyret) else $error("priority 36 code wrong"); // [RULE4]

  property p_watch;
    grant_r.valid && grant_r.idx == 5'd16 |-> grant_r.code == 16'h0320;
  endproperty
  a_watch: assert property (p_watch) else $error("priority 38 code wrong"); // [RULE5]

  property p_tq1cc0;
    grant_r.valid && grant_r.idx == 5'd21 |-> grant_r.code == 16'h0370;
  endproperty
  a_tq1cc0: assert property (p_tq1cc0) else $error("priority 43 code wrong"); // [RULE6]

  property p_tq1cc1;
    grant_r.valid && grant_r.idx == 5'd22 |-> grant_r.code == 16'h0380;
  endproperty
  a_tq1cc1: assert property (p_tq1cc1) else $error("priority 44 code wrong"); // [RULE7]

  property p_tq1cc2;
    grant_r.valid && grant_r.idx == 5'd23 |-> grant_r.code == 16'h0390;
  endproperty
  a_tq1cc2: assert property (p_tq1cc2) else $error("priority 45 code wrong"); // [RULE8]

  property p_tq1cc3;
    grant_r.valid && grant_r.idx == 5'd24 |-> grant_r.code == 16'h03a0;
  endproperty
  a_tq1cc3: assert property (p_tq1cc3) else $error("priority 46 code wrong"); // [RULE9]

  property p_prio;
    clk_en ##1 grant_r.valid |->
      (($past(pend_en) & ((31'h1 << grant_r.idx) - 31'h1)) == 31'h0);
  endproperty
  a_prio: assert property (p_prio) else $error("lower priority granted"); // [RULE10]

  property p_resume;
    s_taken |=> resume_r == $past(next_pc);
  endproperty
  a_resume: assert property (p_resume) else $error("resume address not saved"); // [RULE11]

  property p_vector;
    grant_r.valid |-> grant_r.vector == {16'h0, grant_r.code};
  endproperty
  a_vector: assert property (p_vector) else $error("vector differs from code"); // [RULE12]

  property p_gaps;
    grant_r.valid |-> !(grant_r.code inside {[16'h02c0:16'h02f0], [16'h03d0:16'h0400]});
  endproperty
  a_gaps: assert property (p_gaps) else $error("unassigned code granted"); // [RULE13]

  property p_freeze;
    !clk_en |=> $stable(status_r) && $stable(grant_r) && $stable(resume_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_ack_clear;
    s_taken ##0 !req_all[grant_r.idx] |=> !status_r[$past(grant_r.idx)];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("taken source still pending");

  property p_resume_hold;
    !(clk_en && cpu_ack && grant_r.valid) |=> $stable(resume_r);
  endproperty
  a_resume_hold: assert property (p_resume_hold) else $error("resume address moved"); // [RULE11]

endmodule // maskable_irq_vector_map_mid

// ===== test/cpu_core_model.sv
// cpu core model: takes each granted interrupt after a set wait
`timescale 1ns/1ps
module cpu_core_model (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // grant side
  input  wire irq_map_pkg::grant_s cpu_grant,
  input  wire logic [3:0]          ack_wait,
  output logic                     cpu_ack,
  output logic [31:0]              next_pc
);
  import irq_map_pkg::*;
  logic [4:0] cnt_r;
  ////////////////////////////////////////////////////////////////////////
  // count stays low for two edges after an ack, so a stale grant is never taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r   <= '0;
      cpu_ack <= 1'b0;
      next_pc <= 32'h0;
    end else begin
      cpu_ack <= 1'b0;
      if (!cpu_grant.valid || cpu_ack) begin
        cnt_r <= '0;
      end else if (cnt_r == {1'b0, ack_wait} + 5'd2) begin
        cpu_ack <= 1'b1;
        next_pc <= 32'h8000 + {25'h0, cpu_grant.idx, 2'b00}; // resume point
        cnt_r   <= '0;
      end else begin
        cnt_r <= cnt_r + 5'd1;
      end
    end
  end
endmodule // cpu_core_model

// ===== test/maskable_irq_vector_map_mid_test.sv
// self-checking bench of the mid-range interrupt vector map
`timescale 1ns/1ps
module maskable_irq_vector_map_mid_test;
  import irq_map_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_ack, irq, clk_en;
  logic [31:0] haddr, hwdata, hrdata, next_pc, resume_address, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ext_pin_in;
  logic [27:0] periph_req;
  logic [3:0]  ack_wait;
  grant_s      cpu_grant;
  int          err_count, total_checks;

  maskable_irq_vector_map_mid u_maskable_irq_vector_map_mid (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .periph_req(periph_req), .ext_pin_in(ext_pin_in), .cpu_ack(cpu_ack), .next_pc(next_pc),
    .cpu_grant(cpu_grant), .resume_address(resume_address), .irq(irq));
  cpu_core_model u_cpu_core_model (.hclk(hclk), .hresetn(hresetn), .cpu_grant(cpu_grant),
    .ack_wait(ack_wait), .cpu_ack(cpu_ack), .next_pc(next_pc));

  // clock
  always #25 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // one single ahb-lite word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic pulse(input logic [27:0] bits);
    @(posedge hclk);
    periph_req <= bits;
    @(posedge hclk);
    periph_req <= '0;
  endtask
  function automatic logic [15:0] exp_code(input int i);
    if (i < 14) return 16'h01e0 + 16'(i * 16);
    if (i < 27) return 16'h0300 + 16'((i - 14) * 16);
    return 16'h0410 + 16'((i - 27) * 16);
  endfunction
  // wait for the grant, compare it, then let the core take it
  task automatic expect_grant(input int i);
    int n;
    n = 0;
    while (cpu_grant.valid !== 1'b1 && n < 20) begin
      @(negedge hclk);
      n++;
    end
    check({31'h0, cpu_grant.valid}, 32'h1, "grant valid");
    check({27'h0, cpu_grant.idx}, 32'(i), "grant index");
    check({16'h0, cpu_grant.code}, {16'h0, exp_code(i)}, "code");
    check(cpu_grant.vector, {16'h0, exp_code(i)}, "vector");
    n = 0;
    while (cpu_ack !== 1'b1 && n < 30) begin
      @(negedge hclk);
      n++;
    end
    check({31'h0, cpu_ack}, 32'h1, "core ack seen");
    repeat (2) @(negedge hclk);
    check(resume_address, 32'h8000 + 32'(i * 4), "resume address");
    @(negedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check({31'h0, irq}, 32'h0, "irq after reset");
    ahb(1'b0, OFS_EDGE, 32'h0);
    check(rd, 32'h15, "edge reset");
    ahb(1'b0, OFS_GRANT, 32'h0);
    check(rd, 32'h0, "grant reset");
    ahb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0, "unmapped read");
    ahb(1'b1, OFS_MASK, 32'h7fffffff);
    ahb(1'b0, OFS_MASK, 32'h0);
    check(rd, 32'h7fffffff, "mask readback");
    $display("reset test done");
  endtask
  // every on-chip line in turn, core prompt and slow
  task automatic t_table;
    for (int b = 0; b < 28; b++) begin
      ack_wait <= 4'(b % 4);
      pulse(28'h1 << b);
      expect_grant(b < 17 ? b : b + 3); // each on-chip source entry
    end
    $display("table test done");
  endtask
  task automatic t_pins;
    for (int p = 0; p < 3; p++) begin
      @(posedge hclk);
      ext_pin_in <= 3'b001 << p;
      expect_grant(17 + p); // pin edge request
      @(posedge hclk);
      ext_pin_in <= 3'b000;
      repeat (8) @(negedge hclk);
      check({31'h0, cpu_grant.valid}, 32'h0, "falling edge ignored");
    end
    // pin 8 switched to falling edge only
    ahb(1'b1, OFS_EDGE, 32'h16);
    @(posedge hclk);
    ext_pin_in <= 3'b001;
    repeat (8) @(negedge hclk);
    check({31'h0, cpu_grant.valid}, 32'h0, "rising edge ignored");
    @(posedge hclk);
    ext_pin_in <= 3'b000;
    expect_grant(17); // falling edge request
    ahb(1'b1, OFS_EDGE, 32'h15);
    $display("pin test done");
  endtask
  task automatic t_priority;
    pulse(28'h1c000 | 28'h1 | 28'h8000000);
    expect_grant(0);
    expect_grant(14);
    expect_grant(15);
    expect_grant(16); // watch reference after interval
    expect_grant(30);
    $display("priority test done");
  endtask
  task automatic t_mask;
    ahb(1'b1, OFS_MASK, 32'h7fffff9f);
    pulse(28'h60);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h60, "pending while masked");
    check({31'h0, irq | cpu_grant.valid}, 32'h0, "masked quiet");
    ahb(1'b1, OFS_STATUS, 32'h40);
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h20, "write one clears");
    ahb(1'b1, OFS_MASK, 32'h7fffffff);
    @(negedge hclk);
    check({31'h0, irq}, 32'h1, "irq when unmasked");
    expect_grant(5);
    $display("mask test done");
  endtask
  // a low enable drops a request pulse
  task automatic t_freeze;
    @(posedge hclk);
    clk_en <= 1'b0;
    pulse(28'h2);
    repeat (2) @(negedge hclk);
    check({31'h0, irq}, 32'h0, "request taken while frozen");
    @(posedge hclk);
    clk_en <= 1'b1;
    repeat (3) @(negedge hclk);
    check({30'h0, irq, cpu_grant.valid}, 32'h0, "pulse seen after freeze");
    $display("freeze test done");
  endtask
  // reset in mid-run with a request pending
  task automatic t_rerst;
    pulse(28'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check({30'h0, irq, cpu_grant.valid}, 32'h0, "state after reset");
    check(resume_address, 32'h0, "resume after reset");
    ahb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0, "status after reset");
    ahb(1'b0, OFS_MASK, 32'h0);
    check(rd, 32'h0, "mask after reset");
    $display("mid-run reset test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, periph_req, ext_pin_in} = '0;
    hsize = 3'b010;
    clk_en = 1'b1;
    ack_wait = 4'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_table();
    t_pins();
    t_priority();
    t_mask();
    t_freeze();
    t_rerst();
    finish_test();
  end
  // watchdog
  initial begin
    #(50 * 20000);
    err_count++;
    finish_test();
  end
endmodule // maskable_irq_vector_map_mid_test
